// File: gpio_cfg_defs.svh
// gpio_cfg_defs.svh: subregister indices, reset values, field layout
// assumes: included by the port configuration block and its pin slice
`ifndef GPIO_CFG_DEFS_SVH
`define GPIO_CFG_DEFS_SVH

`define IDX_ALT_ENABLE     8'h02
`define IDX_HIGH_DRIVE     8'h04
`define IDX_RECOVERY_SRC   8'h05
`define IDX_PULLUP         8'h06
`define IDX_ALT_SEL_LOW    8'h07
`define IDX_ALT_SEL_HIGH   8'h08

`define RST_ALT_ENABLE     8'h00
`define RST_HIGH_DRIVE     8'h00
`define RST_RECOVERY_SRC   8'h00
`define RST_PULLUP         8'h00
`define RST_ALT_SEL_LOW    8'h00
`define RST_ALT_SEL_HIGH   8'h00

`define ALT_SEL_W          2
`define PORT_W             8

`endif

// File: gpio_cfg_pkg.sv
// gpio_cfg_pkg.sv: types shared by the port configuration block
// assumes: nothing beyond the defines header
package gpio_cfg_pkg;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_STOP = 2'b10
    } power_state_t;

    typedef logic [1:0] alt_sel_t;

endpackage : gpio_cfg_pkg

// File: gpio_pin_slice.sv
// gpio_pin_slice.sv: one pin's output mux and transition detector
// assumes: pin sample already synchronous to clk_sys
`timescale 1ns/1ps
`include "gpio_cfg_defs.svh"

module gpio_pin_slice (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic                    pin_sample,
    input  wire logic                    capture,
    input  wire logic                    alt_enable_bit,
    input  wire logic                    recovery_source_bit,
    input  wire logic                    alt_select_low_bit,
    input  wire logic                    alt_select_high_bit,
    output logic [`ALT_SEL_W-1:0]        alt_sel,
    output logic                         pin_wake
);
    logic ref_q;
    logic ref_d;

    always_comb begin
        ref_d = capture ? pin_sample : ref_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ref_d;
        end
    end

    // change either way against the level held at stop entry
    always_comb begin
        pin_wake = recovery_source_bit & (pin_sample ^ ref_q);
    end

    // alternate select matters only with the pin enable set
    always_comb begin
        alt_sel = alt_enable_bit ? {alt_select_high_bit, alt_select_low_bit}
                                 : 2'b00;
    end

endmodule : gpio_pin_slice

// File: gpio_pin_config_subregs.sv
// gpio_pin_config_subregs.sv: indirectly addressed pin configuration
// subregisters of an 8-bit port, with stop-mode wake detection
// assumes: port address/control strobes and pin levels synchronous
// to clk_sys; the power controller drives stop_mode
`timescale 1ns/1ps
`include "gpio_cfg_defs.svh"

module gpio_pin_config_subregs #(
    parameter int PORT_W = `PORT_W
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 addr_wr,
    input  wire logic [7:0]           addr_wdata,
    input  wire logic                 ctl_wr,
    input  wire logic                 ctl_rd,
    input  wire logic [7:0]           ctl_wdata,
    input  wire logic [PORT_W-1:0]    pin_in,
    input  wire logic                 stop_mode,
    output logic [7:0]                addr_rdata,
    output logic [7:0]                ctl_rdata,
    output logic [PORT_W-1:0]         high_drive,
    output logic [PORT_W-1:0]         pullup_en,
    output logic [PORT_W-1:0]         alt_enable,
    output logic [2*PORT_W-1:0]       alt_select,
    output logic                      stop_recovery
);
    // ==========================================================
    // registers
    // ==========================================================
    logic [7:0]        index_q, index_d;
    logic [PORT_W-1:0] hde_q, hde_d;
    logic [PORT_W-1:0] smre_q, smre_d;
    logic [PORT_W-1:0] pue_q, pue_d;
    logic [PORT_W-1:0] afs1_q, afs1_d;
    logic [PORT_W-1:0] afs2_q, afs2_d;
    logic [PORT_W-1:0] af_q, af_d;
    logic [7:0]        rdata_q, rdata_d;
    logic [PORT_W-1:0] sel_rd;
    gpio_cfg_pkg::power_state_t pst_q, pst_d;
    logic              recov_q, recov_d;
    logic              capture;
    logic [PORT_W-1:0] wake;
    logic [2*PORT_W-1:0] sel_all;

    always_comb begin
        index_d = addr_wr ? addr_wdata : index_q;
        hde_d  = hde_q;
        smre_d = smre_q;
        pue_d  = pue_q;
        afs1_d = afs1_q;
        afs2_d = afs2_q;
        af_d   = af_q;
        if (ctl_wr) begin
            unique case (index_q)
                `IDX_HIGH_DRIVE:   hde_d  = ctl_wdata[PORT_W-1:0];
                `IDX_RECOVERY_SRC: smre_d = ctl_wdata[PORT_W-1:0];
                `IDX_PULLUP:       pue_d  = ctl_wdata[PORT_W-1:0];
                `IDX_ALT_SEL_LOW:  afs1_d = ctl_wdata[PORT_W-1:0];
                `IDX_ALT_SEL_HIGH: afs2_d = ctl_wdata[PORT_W-1:0];
                `IDX_ALT_ENABLE:   af_d   = ctl_wdata[PORT_W-1:0];
                default: ;
            endcase
        end
        sel_rd = '0;
        unique case (index_q)
            `IDX_HIGH_DRIVE:   sel_rd = hde_q;
            `IDX_RECOVERY_SRC: sel_rd = smre_q;
            `IDX_PULLUP:       sel_rd = pue_q;
            `IDX_ALT_SEL_LOW:  sel_rd = afs1_q;
            `IDX_ALT_SEL_HIGH: sel_rd = afs2_q;
            `IDX_ALT_ENABLE:   sel_rd = af_q;
            default:           sel_rd = '0;
        endcase
        rdata_d = ctl_rd ? 8'(sel_rd) : rdata_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            index_q <= 8'h00;
            hde_q   <= PORT_W'(`RST_HIGH_DRIVE);
            smre_q  <= PORT_W'(`RST_RECOVERY_SRC);
            pue_q   <= PORT_W'(`RST_PULLUP);
            afs1_q  <= PORT_W'(`RST_ALT_SEL_LOW);
            afs2_q  <= PORT_W'(`RST_ALT_SEL_HIGH);
            af_q    <= PORT_W'(`RST_ALT_ENABLE);
            rdata_q <= 8'h00;
        end else begin
            index_q <= index_d;
            hde_q   <= hde_d;
            smre_q  <= smre_d;
            pue_q   <= pue_d;
            afs1_q  <= afs1_d;
            afs2_q  <= afs2_d;
            af_q    <= af_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // per-pin slices
    // ==========================================================
    assign capture = (pst_q == gpio_cfg_pkg::ST_RUN);

    // selects fed from next values so alt_select moves with alt_enable
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        gpio_pin_slice u_slice (
            .clk_sys             (clk_sys),
            .rst_n               (rst_n),
            .pin_sample          (pin_in[i]),
            .capture             (capture),
            .alt_enable_bit      (af_d[i]),
            .recovery_source_bit (smre_q[i]),
            .alt_select_low_bit  (afs1_d[i]),
            .alt_select_high_bit (afs2_d[i]),
            .alt_sel             (sel_all[2*i+1:2*i]),
            .pin_wake            (wake[i])
        );
    end

    // ==========================================================
    // stop-mode recovery
    // ==========================================================
    always_comb begin
        pst_d   = pst_q;
        recov_d = 1'b0;
        unique case (pst_q)
            gpio_cfg_pkg::ST_RUN: begin
                if (stop_mode) pst_d = gpio_cfg_pkg::ST_STOP;
            end
            gpio_cfg_pkg::ST_STOP: begin
                if (|wake) begin
                    recov_d = 1'b1;
                    pst_d   = gpio_cfg_pkg::ST_RUN;
                end else if (!stop_mode) begin
                    pst_d = gpio_cfg_pkg::ST_RUN;
                end
            end
            default: pst_d = gpio_cfg_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pst_q   <= gpio_cfg_pkg::ST_RUN;
            recov_q <= 1'b0;
        end else begin
            pst_q   <= pst_d;
            recov_q <= recov_d;
        end
    end

    // ==========================================================
    // outputs, all registered
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            high_drive <= '0;
            pullup_en  <= '0;
            alt_enable <= '0;
            alt_select <= '0;
        end else begin
            high_drive <= hde_d;
            pullup_en  <= pue_d;
            alt_enable <= af_d;
            alt_select <= sel_all;
        end
    end

    assign addr_rdata    = index_q;
    assign ctl_rdata     = rdata_q;
    assign stop_recovery = recov_q;

    // ==========================================================
    // assertions
    // ==========================================================
    sequence hde_write_s;
        ctl_wr && index_q == `IDX_HIGH_DRIVE;
    endsequence

    hde_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hde_write_s |=> hde_q == $past(ctl_wdata[PORT_W-1:0]))
        else $error("high drive write lost");
    hde_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hde_write_s |=> high_drive == $past(ctl_wdata[PORT_W-1:0]))
        else $error("high drive output wrong");
    smre_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_wr && index_q == `IDX_RECOVERY_SRC
        |=> smre_q == $past(ctl_wdata[PORT_W-1:0]))
        else $error("recovery source write lost");
    pue_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_wr && index_q == `IDX_PULLUP
        |=> pullup_en == $past(ctl_wdata[PORT_W-1:0]))
        else $error("pullup write lost");
    afs1_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_wr && index_q == `IDX_ALT_SEL_LOW
        |=> afs1_q == $past(ctl_wdata[PORT_W-1:0]))
        else $error("select low write lost");
    afs2_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_wr && index_q == `IDX_ALT_SEL_HIGH
        |=> afs2_q == $past(ctl_wdata[PORT_W-1:0]))
        else $error("select high write lost");
    alt_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        alt_select[1:0] != 2'b00 |-> alt_enable[0])
        else $error("select active without enable");
    wake_fire_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pst_q == gpio_cfg_pkg::ST_STOP && |(smre_q & wake)
        |=> stop_recovery)
        else $error("recovery not raised");
    wake_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop_recovery |-> $past(pst_q) == gpio_cfg_pkg::ST_STOP)
        else $error("recovery outside stop");

endmodule : gpio_pin_config_subregs

// File: pin_far_side.sv
// pin_far_side.sv: behavioural model of the pads outside the port
// assumes: drive controls change on the falling edge of clk_sys
`timescale 1ns/1ps

module pin_far_side (
    input  wire logic       clk_sys,
    input  wire logic [7:0] drive_en,
    input  wire logic [7:0] drive_val,
    input  wire logic [7:0] pullup_en,
    output logic      [7:0] pin_level
);
    logic [7:0] float_q = 8'h00;

    // ==========================================
    // pad levels
    // a floating pad wanders, so no stale level is trusted;
    // it moves on the falling edge, away from the sampling edge
    always @(negedge clk_sys) begin
        float_q <= ~float_q;
    end
    assign pin_level = (drive_en & drive_val)
                     | (~drive_en & pullup_en)
                     | (~drive_en & ~pullup_en & float_q);
endmodule : pin_far_side

// File: gpio_pin_config_subregs_tb.sv
// gpio_pin_config_subregs_tb.sv: self-checking bench of the port block
// assumes: design and pad model compiled before this file
`timescale 1ns/1ps

module gpio_pin_config_subregs_tb;
    logic        clk_sys, rst_n, addr_wr, ctl_wr, ctl_rd, stop_mode;
    logic [7:0]  addr_wdata, ctl_wdata, addr_rdata, ctl_rdata, rd;
    logic [7:0]  high_drive, pullup_en, alt_enable, pin_in;
    logic [7:0]  drv_en, drv_val;
    logic [15:0] alt_select;
    logic        stop_recovery;
    int          err_total = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [7:0]  idx_tab [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h02};
    logic [7:0]  dat_tab [6] = '{8'hA5, 8'h08, 8'h5A, 8'hC3, 8'h96, 8'h81};

    gpio_pin_config_subregs gpio_pin_config_subregs_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .addr_wr(addr_wr),
        .addr_wdata(addr_wdata), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
        .ctl_wdata(ctl_wdata), .pin_in(pin_in), .stop_mode(stop_mode),
        .addr_rdata(addr_rdata), .ctl_rdata(ctl_rdata),
        .high_drive(high_drive), .pullup_en(pullup_en),
        .alt_enable(alt_enable), .alt_select(alt_select),
        .stop_recovery(stop_recovery));
    pin_far_side pin_far_side_i (
        .clk_sys(clk_sys), .drive_en(drv_en), .drive_val(drv_val),
        .pullup_en(pullup_en), .pin_level(pin_in));

    // ==========================================
    // clock, timeout, reporting
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 3000) begin
            err_total++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk16

    // ==========================================
    // register access: index write, then control access
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        @(negedge clk_sys);
        addr_wr = 1'b1;
        addr_wdata = idx;
        @(negedge clk_sys);
        addr_wr = 1'b0;
        ctl_wr = 1'b1;
        ctl_wdata = d;
        @(negedge clk_sys);
        ctl_wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
        @(negedge clk_sys);
        addr_wr = 1'b1;
        addr_wdata = idx;
        @(negedge clk_sys);
        addr_wr = 1'b0;
        ctl_rd = 1'b1;
        @(negedge clk_sys);
        ctl_rd = 1'b0;
        d = ctl_rdata;
    endtask : rd_reg
    // flip pads, then count wake pulses over six cycles
    task automatic stop_try(input logic [7:0] flip, input logic [7:0] exp);
        logic [7:0] pulses;
        pulses = 8'h00;
        @(negedge clk_sys);
        drv_val = drv_val ^ flip;
        repeat (6) begin
            @(negedge clk_sys);
            if (stop_recovery === 1'b1) pulses++;
        end
        chk8(pulses, exp);
    endtask : stop_try
    function automatic logic [15:0] alt_exp(input logic [7:0] af, s1, s2);
        logic [15:0] r;
        for (int i = 0; i < 8; i++) r[2*i +: 2] = af[i] ? {s2[i], s1[i]} : 2'b00;
        return r;
    endfunction : alt_exp

    // ==========================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        {addr_wr, ctl_wr, ctl_rd, stop_mode} = 4'h0;
        addr_wdata = 8'h00;
        ctl_wdata = 8'h00;
        drv_en = 8'hFF;
        drv_val = 8'h00;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        foreach (idx_tab[i]) begin
            rd_reg(idx_tab[i], rd);
            chk8(rd, 8'h00);
        end
        chk8(high_drive | pullup_en | alt_enable, 8'h00);
        for (int i = 0; i < 5; i++) wr_reg(idx_tab[i], dat_tab[i]);
        chk16(alt_select, 16'h0000);
        wr_reg(8'h02, 8'h81);
        foreach (idx_tab[i]) begin
            rd_reg(idx_tab[i], rd);
            chk8(rd, dat_tab[i]);
            chk8(addr_rdata, idx_tab[i]);
        end
        chk8(high_drive, 8'hA5);
        chk8(pullup_en, 8'h5A);
        chk8(alt_enable, 8'h81);
        chk16(alt_select, alt_exp(8'h81, 8'hC3, 8'h96));
        wr_reg(8'h09, 8'hFF);
        rd_reg(8'h09, rd);
        chk8(rd, 8'h00);
        chk16({high_drive, pullup_en}, 16'hA55A);
        @(negedge clk_sys);
        stop_mode = 1'b1;
        @(negedge clk_sys);
        stop_try(8'hF7, 8'h00);
        stop_try(8'h08, 8'h01);
        stop_try(8'h08, 8'h01);
        stop_mode = 1'b0;
        repeat (2) @(negedge clk_sys);
        stop_try(8'h08, 8'h00);
        rst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        rd_reg(8'h04, rd);
        chk8(rd, 8'h00);
        chk16(alt_select, 16'h0000);
        conclude();
    end
endmodule : gpio_pin_config_subregs_tb
